// ### hdl/irq_ctl_map.vh
// Constants for the interrupt and exception control unit
`ifndef IRQ_CTL_MAP_VH
`define IRQ_CTL_MAP_VH

// ********************************
// Register offsets
// ********************************
`define OFS_CTRL        12'h000
`define OFS_FAST_ADDR   12'h004
`define OFS_STATUS      12'h008
`define OFS_LEVEL_BASE  12'h100
`define OFS_LEVEL_LAST  12'h2FC

// ********************************
// Control register fields
// ********************************
`define CTRL_FAST_EN_A  0
`define CTRL_DMA_SEL_A  1
`define CTRL_FAST_EN_B  2
`define CTRL_DMA_SEL_B  3

// ********************************
// Reset values and levels
// ********************************
`define RST_CTRL        4'h0
`define RST_FAST_ADDR   32'h0000_0000
`define FAST_LEVEL      3'h7
`define NUM_SRC         128

// ********************************
// Cause codes reported to the core
// ********************************
`define CAUSE_NONE      4'h0
`define CAUSE_UNDEF     4'h1
`define CAUSE_OVF       4'h2
`define CAUSE_BRK       4'h3
`define CAUSE_DBG       4'h4
`define CAUSE_SWI       4'h5
`define CAUSE_PIN       4'h6
`define CAUSE_WDOG      4'h7
`define CAUSE_OSC       4'h8
`define CAUSE_STEP      4'h9
`define CAUSE_PERIPH    4'hA
`define CAUSE_FAST      4'hB

`endif

// ### hdl/irq_ctl.v
// Interrupt and exception control unit with fast interrupt path
// Function
// - Maskable requests blocked when global mask flag clear; priority by software level.
// - Non-maskable interrupts ignore the mask flag; priority is fixed.
// - Instruction-raised interrupts are non-maskable; five kinds exist.
// - Illegal-opcode trap instruction always raises the undefined-instruction interrupt.
// - Overflow trap raises interrupt only when overflow flag is 1.
// - Break trap instruction always raises the break interrupt.
// - Debug break raises its own interrupt, reserved for tools.
// - Numbered trap takes 0 to 255; 0 to 127 share peripheral handlers.
// - Traps 0 to 127 save stack-select flag, clear it, restore on return.
// - Traps 128 to 255 leave stack selection unchanged.
// - Falling edge on the external pin raises the pin interrupt.
// - Four special interrupts, all non-maskable: pin, watchdog, oscillator, single-step.
// - Watchdog timeout raises the watchdog special interrupt.
// - Oscillator stop detection raises its special interrupt.
// - Peripheral interrupts use vectors of trap numbers 0 to 127.
// - Any peripheral at level 7, the highest level, can be the fast interrupt when it wins arbitration.
// - Fast accept copies flags and pc to shadows, jumps to fast address.
// - Fast return restores flags and pc from the shadows.
`timescale 1ns/1ps
`default_nettype none
`include "irq_ctl_map.vh"

module irq_ctl (
  input  wire         pclk,
  input  wire         presetn,
  input  wire         clk_en,
  // APB slave
  input  wire         psel,
  input  wire         penable,
  input  wire         pwrite,
  input  wire [11:0]  paddr,
  input  wire [31:0]  pwdata,
  output wire         pready,
  output reg  [31:0]  prdata,
  output wire         pslverr,
  // Peripheral requests, same clock
  input  wire [127:0] periph_req,
  // Special sources
  input  wire         nmi_pin_n,
  input  wire         wdog_timeout,
  input  wire         osc_stop,
  input  wire         single_step,
  // Core side
  input  wire         exec_valid,
  input  wire         exec_illegal_opcode_trap,
  input  wire         exec_overflow_trap,
  input  wire         exec_break_trap,
  input  wire         exec_debug_break_trap,
  input  wire         exec_swi,
  input  wire [7:0]   exec_swi_num,
  input  wire         exec_fast_return,
  input  wire         exec_normal_return,
  input  wire         cpu_irq_mask_flag,
  input  wire         cpu_overflow_flag,
  input  wire [2:0]   cpu_prio_level,
  input  wire [31:0]  cpu_flags_word,
  input  wire [31:0]  cpu_pc,
  input  wire         cpu_stack_sel,
  input  wire         cpu_ready,
  output reg          take_valid,
  output reg  [3:0]   take_cause,
  output reg  [7:0]   take_vector,
  output reg          take_fast,
  output reg  [31:0]  take_target,
  output reg          take_stack_sel,
  output reg          ret_valid,
  output reg  [31:0]  ret_flags,
  output reg  [31:0]  ret_pc,
  output reg          ret_stack_sel,
  output reg  [127:0] periph_ack
);

  // ********************************
  // Functions
  // ********************************
  // Pending flag update; a new event wins over the clear
  function pend_next;
    input set;
    input q;
    input clr;
    begin
      pend_next = set | (q & ~clr);
    end
  endfunction

  function is_reg;
    input [11:0] a;
    input [11:0] o;
    begin
      is_reg = (a == o);
    end
  endfunction

  // ********************************
  // Registers
  // ********************************
  reg [3:0]   ctrl_q;
  reg [31:0]  fast_handler_addr_q;
  reg [2:0]   request_level_field [0:`NUM_SRC-1];
  reg [31:0]  saved_flags_shadow_q;
  reg [31:0]  saved_pc_shadow_q;
  reg         in_fast_q;
  reg [7:0]   stack_depth_q;
  reg [7:0]   saved_sel_q;
  reg         nmi_s1_q;
  reg         nmi_s2_q;
  reg         nmi_s3_q;
  reg         pin_pend_q;
  reg         wdog_pend_q;
  reg         osc_pend_q;
  reg         wdog_prev_q;
  reg         osc_prev_q;
  integer     i;
  integer     j;

  // ********************************
  // APB slave, zero wait state
  // ********************************
  wire wr_en = psel & penable & pwrite & clk_en;
  wire lvl_hit = (paddr >= `OFS_LEVEL_BASE) && (paddr <= `OFS_LEVEL_LAST)
                 && (paddr[1:0] == 2'b00);
  wire [6:0] lvl_idx = paddr[8:2] - 7'h40;
  wire mapped = is_reg(paddr, `OFS_CTRL) | is_reg(paddr, `OFS_FAST_ADDR)
                | is_reg(paddr, `OFS_STATUS) | lvl_hit;

  assign pready  = 1'b1;
  assign pslverr = psel & penable & ~mapped;

  wire fast_on = ctrl_q[`CTRL_FAST_EN_A] & ctrl_q[`CTRL_FAST_EN_B]
                 & ~ctrl_q[`CTRL_DMA_SEL_A] & ~ctrl_q[`CTRL_DMA_SEL_B];

  always @* begin
    prdata = 32'h0000_0000;
    if (is_reg(paddr, `OFS_CTRL))
      prdata = {28'h000_0000, ctrl_q};
    else if (is_reg(paddr, `OFS_FAST_ADDR))
      prdata = fast_handler_addr_q;
    else if (is_reg(paddr, `OFS_STATUS))
      prdata = {24'h00_0000, stack_depth_q[3:0], osc_pend_q, wdog_pend_q, pin_pend_q,
                in_fast_q};
    else if (lvl_hit)
      prdata = {29'h0000_0000, request_level_field[lvl_idx]};
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q              <= `RST_CTRL;
      fast_handler_addr_q <= `RST_FAST_ADDR;
      for (i = 0; i < `NUM_SRC; i = i + 1)
        request_level_field[i] <= 3'h0;
    end else if (wr_en) begin
      if (is_reg(paddr, `OFS_CTRL))
        ctrl_q <= pwdata[3:0];
      if (is_reg(paddr, `OFS_FAST_ADDR))
        fast_handler_addr_q <= pwdata;
      if (lvl_hit)
        request_level_field[lvl_idx] <= pwdata[2:0];
    end
  end

  // ********************************
  // Special source capture
  // ********************************
  wire pin_fall = nmi_s3_q & ~nmi_s2_q;
  wire wdog_rise = wdog_timeout & ~wdog_prev_q;
  wire osc_rise = osc_stop & ~osc_prev_q;

  // ********************************
  // Peripheral arbitration
  // ********************************
  reg [2:0] best_lvl;
  reg [6:0] best_idx;
  reg       best_ok;
  always @* begin
    best_lvl = 3'h0;
    best_idx = 7'h00;
    best_ok  = 1'b0;
    for (j = 0; j < `NUM_SRC; j = j + 1)
      if (periph_req[j] && request_level_field[j] != 3'h0
          && request_level_field[j] > best_lvl) begin
        best_lvl = request_level_field[j];
        best_idx = j[6:0];
        best_ok  = 1'b1;
      end
  end

  wire periph_go = best_ok & cpu_irq_mask_flag & (best_lvl > cpu_prio_level);
  wire fast_go = periph_go & fast_on & (best_lvl == `FAST_LEVEL) & ~in_fast_q;

  // ********************************
  // Acceptance, fixed priority
  // ********************************
  reg       acc;
  reg [3:0] cause;
  reg [7:0] vec;
  reg       use_fast;
  reg       swap_sel;
  always @* begin
    acc      = 1'b1;
    cause    = `CAUSE_NONE;
    vec      = 8'h00;
    use_fast = 1'b0;
    swap_sel = 1'b0;
    if (exec_valid && exec_illegal_opcode_trap)
      cause = `CAUSE_UNDEF;
    else if (exec_valid && exec_overflow_trap && cpu_overflow_flag)
      cause = `CAUSE_OVF;
    else if (exec_valid && exec_break_trap)
      cause = `CAUSE_BRK;
    else if (exec_valid && exec_debug_break_trap)
      cause = `CAUSE_DBG;
    else if (exec_valid && exec_swi) begin
      cause    = `CAUSE_SWI;
      vec      = exec_swi_num;
      swap_sel = ~exec_swi_num[7];
    end else if (pin_pend_q)
      cause = `CAUSE_PIN;
    else if (wdog_pend_q)
      cause = `CAUSE_WDOG;
    else if (osc_pend_q)
      cause = `CAUSE_OSC;
    else if (single_step)
      cause = `CAUSE_STEP;
    else if (fast_go) begin
      cause    = `CAUSE_FAST;
      vec      = {1'b0, best_idx};
      use_fast = 1'b1;
    end else if (periph_go) begin
      cause    = `CAUSE_PERIPH;
      vec      = {1'b0, best_idx};
      swap_sel = 1'b1;
    end else
      acc = 1'b0;
  end

  wire fire = acc & cpu_ready & clk_en;
  wire pop = exec_normal_return & cpu_ready & clk_en & ~fire;
  // Fast return outranks a normal return in the same cycle
  wire fret_go = exec_fast_return & in_fast_q & cpu_ready & clk_en & ~fire;
  wire pop_go = pop & ~fret_go;
  wire ack_go = fire & (cause == `CAUSE_FAST || cause == `CAUSE_PERIPH);

  // ********************************
  // Special source synchronisers and pending flags
  // ********************************
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      nmi_s1_q    <= 1'b1;
      nmi_s2_q    <= 1'b1;
      nmi_s3_q    <= 1'b1;
      wdog_prev_q <= 1'b0;
      osc_prev_q  <= 1'b0;
      pin_pend_q  <= 1'b0;
      wdog_pend_q <= 1'b0;
      osc_pend_q  <= 1'b0;
    end else if (clk_en) begin
      nmi_s1_q    <= nmi_pin_n;
      nmi_s2_q    <= nmi_s1_q;
      nmi_s3_q    <= nmi_s2_q;
      wdog_prev_q <= wdog_timeout;
      osc_prev_q  <= osc_stop;
      pin_pend_q  <= pend_next(pin_fall, pin_pend_q, fire && cause == `CAUSE_PIN);
      wdog_pend_q <= pend_next(wdog_rise, wdog_pend_q, fire && cause == `CAUSE_WDOG);
      osc_pend_q  <= pend_next(osc_rise, osc_pend_q, fire && cause == `CAUSE_OSC);
    end
  end

  // ********************************
  // Fast path shadows
  // ********************************
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      saved_flags_shadow_q <= 32'h0000_0000;
      saved_pc_shadow_q    <= 32'h0000_0000;
      in_fast_q            <= 1'b0;
    end else if (fire && use_fast) begin
      saved_flags_shadow_q <= cpu_flags_word;
      saved_pc_shadow_q    <= cpu_pc;
      in_fast_q            <= 1'b1;
    end else if (fret_go) begin
      in_fast_q            <= 1'b0;
    end
  end

  // ********************************
  // Stack-select save for the normal path
  // ********************************
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stack_depth_q <= 8'h00;
      saved_sel_q   <= 8'h00;
    end else if (fire && !use_fast) begin
      saved_sel_q   <= {saved_sel_q[6:0], cpu_stack_sel};
      stack_depth_q <= stack_depth_q + 8'h01;
    end else if (pop_go) begin
      saved_sel_q   <= {1'b0, saved_sel_q[7:1]};
      if (stack_depth_q != 8'h00)
        stack_depth_q <= stack_depth_q - 8'h01;
    end
  end

  // ********************************
  // Accept outputs to the core
  // ********************************
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      take_valid     <= 1'b0;
      take_cause     <= `CAUSE_NONE;
      take_vector    <= 8'h00;
      take_fast      <= 1'b0;
      take_target    <= 32'h0000_0000;
      take_stack_sel <= 1'b0;
    end else if (clk_en) begin
      take_valid <= fire;
      if (fire) begin
        take_cause     <= cause;
        take_vector    <= vec;
        take_fast      <= use_fast;
        take_target    <= use_fast ? fast_handler_addr_q : 32'h0000_0000;
        take_stack_sel <= swap_sel ? 1'b0 : cpu_stack_sel;
      end
    end
  end

  // ********************************
  // Peripheral acknowledge
  // ********************************
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      periph_ack <= 128'h0;
    end else if (clk_en) begin
      periph_ack <= 128'h0;
      if (ack_go)
        periph_ack[best_idx] <= 1'b1;
    end
  end

  // ********************************
  // Return outputs to the core
  // ********************************
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ret_valid     <= 1'b0;
      ret_flags     <= 32'h0000_0000;
      ret_pc        <= 32'h0000_0000;
      ret_stack_sel <= 1'b0;
    end else if (clk_en) begin
      ret_valid <= fret_go | pop_go;
      if (fret_go) begin
        ret_flags     <= saved_flags_shadow_q;
        ret_pc        <= saved_pc_shadow_q;
        ret_stack_sel <= cpu_stack_sel;
      end else if (pop_go) begin
        ret_flags     <= cpu_flags_word;
        ret_pc        <= cpu_pc;
        ret_stack_sel <= saved_sel_q[0];
      end
    end
  end

endmodule // irq_ctl
`default_nettype wire

// ### sim/irq_ctl_asserts.sv
// Checker for the interrupt control unit ports
`timescale 1ns/1ps
`default_nettype none
`include "irq_ctl_map.vh"
module irq_ctl_asserts (
  input wire logic         pclk,
  input wire logic         presetn,
  input wire logic         clk_en,
  input wire logic         cpu_ready,
  input wire logic         exec_valid,
  input wire logic         exec_illegal_opcode_trap,
  input wire logic         exec_overflow_trap,
  input wire logic         exec_break_trap,
  input wire logic         cpu_overflow_flag,
  input wire logic         cpu_irq_mask_flag,
  input wire logic         cpu_stack_sel,
  input wire logic         take_valid,
  input wire logic [3:0]   take_cause,
  input wire logic [7:0]   take_vector,
  input wire logic         take_fast,
  input wire logic         take_stack_sel,
  input wire logic [127:0] periph_ack
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire go = clk_en && cpu_ready && exec_valid;
  wire ovf_hit = exec_overflow_trap && cpu_overflow_flag;
  a_undef_take:
    assert property (go && exec_illegal_opcode_trap |=> take_valid
      && take_cause == `CAUSE_UNDEF) else $error("undef not taken");
  a_brk_take:
    assert property (go && exec_break_trap && !exec_illegal_opcode_trap && !ovf_hit
      |=> take_valid && take_cause == `CAUSE_BRK) else $error("break not taken");
  a_ovf_flag:
    assert property (take_valid && take_cause == `CAUSE_OVF |-> $past(cpu_overflow_flag))
      else $error("overflow taken with flag clear");
  a_swi_low:
    assert property (take_valid && take_cause == `CAUSE_SWI && !take_vector[7]
      |-> !take_stack_sel) else $error("low trap kept stack select");
  a_swi_high:
    assert property (take_valid && take_cause == `CAUSE_SWI && take_vector[7]
      |-> take_stack_sel == $past(cpu_stack_sel)) else $error("high trap moved stack");
  a_mask_gate:
    assert property (take_valid && take_cause == `CAUSE_PERIPH |-> $past(cpu_irq_mask_flag))
      else $error("masked request taken");
  a_ack_take:
    assert property (|periph_ack |-> take_valid && (take_cause == `CAUSE_PERIPH
      || take_cause == `CAUSE_FAST)) else $error("ack without accept");
  a_ack_one:
    assert property ($onehot0(periph_ack)) else $error("several acks");
  a_fast_cause:
    assert property (take_valid && take_fast |-> take_cause == `CAUSE_FAST)
      else $error("fast flag with wrong cause");
endmodule // irq_ctl_asserts
bind irq_ctl irq_ctl_asserts i_irq_ctl_asserts (.pclk, .presetn, .clk_en, .cpu_ready,
  .exec_valid, .exec_illegal_opcode_trap, .exec_overflow_trap, .exec_break_trap,
  .cpu_overflow_flag, .cpu_irq_mask_flag, .cpu_stack_sel, .take_valid, .take_cause,
  .take_vector, .take_fast, .take_stack_sel, .periph_ack);
`default_nettype wire

// ### sim/periph_src.sv
// Peripheral request source model
`timescale 1ns/1ps
`default_nettype none
module periph_src (
  input  wire logic         pclk,
  input  wire logic         presetn,
  input  wire logic         fire,
  input  wire logic [6:0]   idx,
  input  wire logic [127:0] periph_ack,
  output var  logic [127:0] periph_req
);
  // Level request held until acknowledged
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      periph_req <= '0;
    end else begin
      periph_req <= (periph_req & ~periph_ack) | ({{127{1'b0}}, fire} << idx);
    end
  end
endmodule // periph_src
`default_nettype wire

// ### sim/interrupt_exception_control_tb_top.sv
// Testbench for the interrupt control unit
`timescale 1ns/1ps
`default_nettype none
`include "irq_ctl_map.vh"
module interrupt_exception_control_tb_top;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, rd, cpu_flags_word = 0, cpu_pc = 0, take_target;
  logic [31:0] ret_flags, ret_pc;
  logic nmi_pin_n = 1, wdog_timeout = 0, osc_stop = 0, exec_valid = 0, err, fire = 0;
  logic exec_fast_return = 0, exec_normal_return = 0, cpu_irq_mask_flag = 0;
  logic cpu_overflow_flag = 1, cpu_stack_sel = 0, take_valid, take_fast, take_stack_sel;
  logic ret_valid, ret_stack_sel, clk_en = 1, single_step = 0;
  logic [4:0] ex = 0;
  logic [6:0] idx = 0;
  logic [7:0] exec_swi_num = 0, take_vector;
  logic [3:0] take_cause;
  logic [127:0] periph_req, periph_ack;
  int n_fail = 0, num_checks = 0;
  wire exec_illegal_opcode_trap = ex[0];
  wire exec_overflow_trap = ex[1];
  wire exec_break_trap = ex[2];
  wire exec_debug_break_trap = ex[3];
  wire exec_swi = ex[4];
  irq_ctl i_irq_ctl (.pclk, .presetn, .clk_en, .psel, .penable, .pwrite, .paddr,
    .pwdata, .pready, .prdata, .pslverr, .periph_req, .nmi_pin_n, .wdog_timeout, .osc_stop,
    .single_step, .exec_valid, .exec_illegal_opcode_trap, .exec_overflow_trap,
    .exec_break_trap, .exec_debug_break_trap, .exec_swi, .exec_swi_num, .exec_fast_return,
    .exec_normal_return, .cpu_irq_mask_flag, .cpu_overflow_flag, .cpu_prio_level(3'h0),
    .cpu_flags_word, .cpu_pc, .cpu_stack_sel, .cpu_ready(1'b1), .take_valid, .take_cause,
    .take_vector, .take_fast, .take_target, .take_stack_sel, .ret_valid, .ret_flags,
    .ret_pc, .ret_stack_sel, .periph_ack);
  periph_src i_periph_src (.pclk, .presetn, .fire, .idx, .periph_ack, .periph_req);
  initial forever #50 pclk = ~pclk;
  task automatic chk(input logic ok, input string m);
    num_checks++;
    if (ok !== 1'b1) begin
      n_fail++;
      $display("Error %0t %s", $time, m);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 0;
    penable <= 0;
  endtask
  task automatic trap(input logic [4:0] k, input logic [3:0] c);
    @(posedge pclk);
    ex <= k;
    exec_valid <= 1;
    @(posedge pclk);
    ex <= 0;
    exec_valid <= 0;
    #1;
    chk(c == `CAUSE_NONE ? take_valid === 0 : take_valid === 1 && take_cause === c, "trap");
  endtask
  task automatic wait_take(input logic [3:0] c);
    for (int i = 0; i < 20; i++) begin
      @(posedge pclk);
      #1;
      if (take_valid === 1'b1) break;
    end
    chk(take_valid === 1 && take_cause === c, "take");
  endtask
  task automatic raise(input logic [6:0] n);
    @(posedge pclk);
    idx <= n;
    fire <= 1;
    @(posedge pclk);
    fire <= 0;
  endtask
  task automatic t_regs();
    apb(0, `OFS_CTRL, 0);
    chk(rd === 32'h0 && err === 0, "ctrl reset");
    apb(0, 12'h00C, 0);
    chk(err === 1 && rd === 32'h0, "unmapped");
    apb(1, `OFS_LEVEL_BASE + 12'h014, 32'h3);
    apb(0, `OFS_LEVEL_BASE + 12'h014, 0);
    chk(rd === 32'h3, "level");
  endtask
  task automatic t_traps();
    trap(5'h01, `CAUSE_UNDEF);
    trap(5'h02, `CAUSE_OVF);
    trap(5'h04, `CAUSE_BRK);
    trap(5'h08, `CAUSE_DBG);
    trap(5'h06, `CAUSE_OVF);
    @(posedge pclk) clk_en <= 0;
    trap(5'h04, `CAUSE_NONE);
    @(posedge pclk) clk_en <= 1;
    cpu_overflow_flag <= 0;
    trap(5'h02, `CAUSE_NONE);
  endtask
  task automatic t_swi();
    cpu_stack_sel <= 1;
    exec_swi_num <= 8'h05;
    trap(5'h10, `CAUSE_SWI);
    chk(take_vector === 8'h05 && take_stack_sel === 0, "swi low");
    @(posedge pclk) exec_normal_return <= 1;
    @(posedge pclk) exec_normal_return <= 0;
    #1 chk(ret_stack_sel === 1, "stack restore");
    exec_swi_num <= 8'hC8;
    trap(5'h10, `CAUSE_SWI);
    chk(take_vector === 8'hC8 && take_stack_sel === 1, "swi high");
  endtask
  task automatic t_special();
    @(posedge pclk) nmi_pin_n <= 0;
    wait_take(`CAUSE_PIN);
    @(posedge pclk) wdog_timeout <= 1;
    wait_take(`CAUSE_WDOG);
    @(posedge pclk) osc_stop <= 1;
    wait_take(`CAUSE_OSC);
    @(posedge pclk) single_step <= 1;
    wait_take(`CAUSE_STEP);
    @(posedge pclk) single_step <= 0;
  endtask
  task automatic t_periph();
    raise(7'h05);
    repeat (6) @(posedge pclk);
    chk(periph_req[5] === 1, "masked held");
    cpu_irq_mask_flag <= 1;
    wait_take(`CAUSE_PERIPH);
    chk(take_vector === 8'h05 && take_fast === 0, "periph");
  endtask
  task automatic t_fast();
    apb(1, `OFS_CTRL, 32'h5);
    apb(1, `OFS_FAST_ADDR, 32'h0000_8000);
    apb(1, `OFS_LEVEL_BASE + 12'h024, 32'h7);
    cpu_flags_word <= 32'h0000_00A5;
    cpu_pc <= 32'h0000_1234;
    raise(7'h09);
    wait_take(`CAUSE_FAST);
    chk(take_fast === 1 && take_target === 32'h0000_8000, "fast");
    @(posedge pclk);
    exec_fast_return <= 1;
    cpu_flags_word <= 32'h0;
    cpu_pc <= 32'h0;
    @(posedge pclk) exec_fast_return <= 0;
    #1 chk(ret_valid === 1 && ret_flags === 32'h0000_00A5 && ret_pc === 32'h0000_1234, "fret");
  endtask
  task automatic print_verdict();
    $display("Checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    #200_000;
    n_fail++;
    print_verdict();
  end
  initial begin
    repeat (6) @(posedge pclk);
    presetn <= 1;
    t_regs();
    t_traps();
    t_swi();
    t_special();
    t_periph();
    t_fast();
    print_verdict();
  end
endmodule // interrupt_exception_control_tb_top
`default_nettype wire
